/* logic/fcc_pkg.sv */
`default_nettype none
package fcc_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] FCC_CFG_A_OFS = 8'h00;
  localparam logic [7:0] FCC_CFG_B_OFS = 8'h01;
  localparam logic [7:0] FCC_CFG_A_RST = 8'hd4;
  localparam logic [7:0] FCC_CFG_B_RST = 8'h3d;
  // ==========================================================
  // first configuration register fields
  localparam int FCC_A_OVT_IE = 7;
  localparam int FCC_A_MODE_HI = 6;
  localparam int FCC_A_MODE_LO = 5;
  localparam int FCC_A_FAULT_EN = 4;
  localparam int FCC_A_POL = 3;
  localparam int FCC_A_SPD_IE = 2;
  localparam int FCC_A_GLB_IE = 1;
  localparam int FCC_A_START = 0;
  // second configuration register fields
  localparam int FCC_B_SRST = 7;
  // ==========================================================
  // timing
  localparam int FCC_CLK_PERIOD_NS = 100;
  localparam int FCC_PWM_TICK_NS = 1000;
  localparam int FCC_PWM_TICK_CYC =
    (FCC_PWM_TICK_NS + FCC_CLK_PERIOD_NS - 1) / FCC_CLK_PERIOD_NS;
  localparam int FCC_LOOP_PERIOD_NS = 100000;
  localparam int FCC_LOOP_CYC = FCC_LOOP_PERIOD_NS / FCC_CLK_PERIOD_NS;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    FCC_MODE_DUTY = 2'b00,
    FCC_MODE_SPEED = 2'b01,
    FCC_MODE_AUTO = 2'b10,
    FCC_MODE_MAX = 2'b11
  } fcc_mode_t;
  typedef enum logic [3:0] {
    FCC_ST_IDLE = 4'b0000,
    FCC_ST_ADDR = 4'b0001,
    FCC_ST_ADDR_ACK = 4'b0010,
    FCC_ST_CMD = 4'b0011,
    FCC_ST_CMD_ACK = 4'b0100,
    FCC_ST_WDATA = 4'b0101,
    FCC_ST_WDATA_ACK = 4'b0110,
    FCC_ST_RDATA = 4'b0111,
    FCC_ST_RDATA_ACK = 4'b1000
  } fcc_bus_t;
endpackage
`default_nettype wire

/* logic/fcc_fan_ctrl_config_regs.sv */
// Operation
// RULE1: overtemp enable set: either overtemp flag raises an interrupt.
// RULE2: overtemp enable clear: no alert from overtemp, pin still driven low.
// RULE3: two drive-select bits pick max, auto, software duty or speed mode.
// RULE4: max mode drives the larger of remote and local derived duty.
// RULE5: auto mode, the reset mode, derives duty from remote temperature.
// RULE6: software duty mode outputs the host-written duty value directly.
// RULE7: speed mode steps duty in a loop to hold speed_pulse_input at target_speed.
// RULE8: fault enable set makes fault pin active; clear keeps it released.
// RULE9: polarity 0 drives low at full duty; 1 releases high.
// RULE10: speed enable set: stall or speed limit flag pulls alert low.
// RULE11: speed enable clear: fan out-of-range gives no interrupt.
// RULE12: global alert enable gates the alert line; clear after reset.
// RULE13: monitoring start clear: only software duty mode works.
// RULE14: writing soft reset bit resets everything; bit reads zero. Code restores only cfg_a, cfg_b, loop_duty and the bus state.
// RULE15: soft reset acts on last data bit rising clock, no acknowledge.
// RULE16: all interrupts reach the host on the alert line.
// RULE17: host uses byte read and write transactions addressed by offset.
`timescale 1ns/1ns
`default_nettype none
module fcc_fan_ctrl_config_regs
  import fcc_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h18,
  parameter logic [7:0] TEMP_LOW = 8'h28,
  parameter logic [7:0] TEMP_HIGH = 8'h50
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic smb_scl,
  input wire logic smb_sda_in,
  output logic smb_sda_out,
  output logic smb_sda_oe_n,
  output logic smb_alert_oe_n,
  input wire logic local_overtemp_flag,
  input wire logic remote_overtemp_flag,
  input wire logic fan_stall_flag,
  input wire logic speed_limit_flag,
  input wire logic [7:0] local_temp,
  input wire logic [7:0] remote_temp,
  input wire logic [7:0] duty_setting_reg,
  input wire logic [15:0] target_speed,
  input wire logic [15:0] speed_pulse_input,
  output logic overtemp_output_pin_n,
  output logic fault_oe_n,
  output logic speed_range_irq,
  output logic pwm_out,
  output logic pwm_oe_n,
  output logic soft_reset
);
  // ==========================================================
  // functions
  function automatic logic [7:0] temp_to_duty(input logic [7:0] t);
    logic [9:0] d;
    d = 10'h000;
    if (t <= TEMP_LOW) begin
      temp_to_duty = 8'h00;
    end else if (t >= TEMP_HIGH) begin
      temp_to_duty = 8'hff;
    end else begin
      d = {2'b00, t - TEMP_LOW} << 2;
      temp_to_duty = (d > 10'h0ff) ? 8'hff : d[7:0];
    end
  endfunction

  function automatic logic [7:0] read_reg(input logic [7:0] p,
    input logic [7:0] a, input logic [7:0] b);
    if (p == FCC_CFG_A_OFS) begin
      read_reg = a;
    end else if (p == FCC_CFG_B_OFS) begin
      read_reg = {1'b0, b[6:0]};
    end else begin
      read_reg = 8'h00;
    end
  endfunction

  // ==========================================================
  // bus slave
  fcc_bus_t st, next_st;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] ptr, next_ptr;
  logic [7:0] dout, next_dout;
  logic rw, next_rw;
  logic drv, next_drv;
  logic wr_stb, next_wr_stb;
  logic next_soft_reset;
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:0] cfg_a, next_cfg_a;
  logic [7:0] cfg_b, next_cfg_b;

  assign scl_rise = smb_scl & ~scl_q;
  assign scl_fall = ~smb_scl & scl_q;
  assign bus_start = smb_scl & scl_q & sda_q & ~smb_sda_in;
  assign bus_stop = smb_scl & scl_q & ~sda_q & smb_sda_in;

  always_comb begin
    next_st = st;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_dout = dout;
    next_rw = rw;
    next_drv = drv;
    next_wr_stb = 1'b0;
    next_soft_reset = 1'b0;
    if (bus_stop) begin
      next_st = FCC_ST_IDLE;
      next_drv = 1'b0;
    end else if (bus_start) begin
      next_st = FCC_ST_ADDR;
      next_bitcnt = 4'h0;
      next_drv = 1'b0;
    end else begin
      case (st)
        FCC_ST_ADDR, FCC_ST_CMD, FCC_ST_WDATA: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], smb_sda_in};
            next_bitcnt = bitcnt + 4'h1;
            // reset before the ack slot, so no acknowledge follows
            if (st == FCC_ST_WDATA && bitcnt == 4'h7 &&
                ptr == FCC_CFG_B_OFS && shreg[6]) begin // RULE15
              next_soft_reset = 1'b1; // RULE14
              next_st = FCC_ST_IDLE;
            end
          end else if (scl_fall && bitcnt == 4'h8) begin
            next_bitcnt = 4'h0;
            next_drv = 1'b1;
            if (st == FCC_ST_ADDR) begin
              next_rw = shreg[0];
              next_st = FCC_ST_ADDR_ACK;
              if (shreg[7:1] != SLAVE_ADDR) begin
                next_st = FCC_ST_IDLE;
                next_drv = 1'b0;
              end
            end else if (st == FCC_ST_CMD) begin
              next_ptr = shreg; // RULE17
              next_st = FCC_ST_CMD_ACK;
            end else begin
              next_wr_stb = 1'b1; // RULE17
              next_st = FCC_ST_WDATA_ACK;
            end
          end
        end
        FCC_ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              next_dout = read_reg(ptr, cfg_a, cfg_b); // RULE17
              next_drv = ~next_dout[7];
              next_st = FCC_ST_RDATA;
            end else begin
              next_drv = 1'b0;
              next_st = FCC_ST_CMD;
            end
          end
        end
        FCC_ST_CMD_ACK, FCC_ST_WDATA_ACK: begin
          if (scl_fall) begin
            next_drv = 1'b0;
            next_st = FCC_ST_WDATA;
          end
        end
        FCC_ST_RDATA: begin
          if (scl_rise) begin
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              next_drv = 1'b0;
              next_st = FCC_ST_RDATA_ACK;
            end else begin
              next_dout = {dout[6:0], 1'b0};
              next_drv = ~dout[6];
            end
          end
        end
        FCC_ST_RDATA_ACK: begin
          // master nack ends the read; ack sends the same byte again
          if (scl_rise && smb_sda_in) begin
            next_st = FCC_ST_IDLE;
          end else if (scl_fall) begin
            next_bitcnt = 4'h0;
            next_dout = read_reg(ptr, cfg_a, cfg_b);
            next_drv = ~next_dout[7];
            next_st = FCC_ST_RDATA;
          end
        end
        default: begin
          next_st = FCC_ST_IDLE;
          next_drv = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= FCC_ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      dout <= 8'h00;
      rw <= 1'b0;
      drv <= 1'b0;
      wr_stb <= 1'b0;
      soft_reset <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      st <= next_st;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      dout <= next_dout;
      rw <= next_rw;
      drv <= next_drv;
      wr_stb <= next_wr_stb;
      soft_reset <= next_soft_reset;
      scl_q <= smb_scl;
      sda_q <= smb_sda_in;
    end
  end

  assign smb_sda_out = 1'b0;
  assign smb_sda_oe_n = ~drv;

  // ==========================================================
  // configuration registers
  always_comb begin
    next_cfg_a = cfg_a;
    next_cfg_b = cfg_b;
    if (soft_reset) begin
      next_cfg_a = FCC_CFG_A_RST; // RULE14
      next_cfg_b = FCC_CFG_B_RST & 8'h7f;
    end else if (wr_stb && ptr == FCC_CFG_A_OFS) begin
      next_cfg_a = shreg;
    end else if (wr_stb && ptr == FCC_CFG_B_OFS) begin
      next_cfg_b = {1'b0, shreg[6:0]}; // RULE14
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_a <= FCC_CFG_A_RST;
      cfg_b <= FCC_CFG_B_RST & 8'h7f;
    end else begin
      cfg_a <= next_cfg_a;
      cfg_b <= next_cfg_b;
    end
  end

  // ==========================================================
  // duty selection, speed loop and pwm
  fcc_mode_t mode;
  logic [7:0] duty_now, rem_duty, loc_duty;
  logic [7:0] loop_duty, next_loop_duty;
  logic [7:0] pwm_cnt, next_pwm_cnt;
  logic [15:0] tick_cnt, next_tick_cnt;
  logic [15:0] loop_cnt, next_loop_cnt;
  logic pulse_on, ovt_any, spd_any, irq_any;
  logic next_pwm_out, next_pwm_oe_n, next_overtemp_output_pin_n;
  logic next_fault_oe_n, next_speed_range_irq, next_smb_alert_oe_n;

  assign mode = fcc_mode_t'({cfg_a[FCC_A_MODE_HI], cfg_a[FCC_A_MODE_LO]});
  assign rem_duty = temp_to_duty(remote_temp);
  assign loc_duty = temp_to_duty(local_temp);

  always_comb begin
    case (mode) // RULE3
      FCC_MODE_DUTY: duty_now = duty_setting_reg; // RULE6
      FCC_MODE_SPEED: duty_now = loop_duty; // RULE7
      FCC_MODE_AUTO: duty_now = rem_duty; // RULE5
      FCC_MODE_MAX: duty_now = (rem_duty > loc_duty) ? rem_duty :
        loc_duty; // RULE4
      default: duty_now = 8'h00;
    endcase
    if (!cfg_a[FCC_A_START] && mode != FCC_MODE_DUTY) begin
      duty_now = 8'h00; // RULE13
    end
  end

  always_comb begin
    next_tick_cnt = tick_cnt + 16'h0001;
    next_pwm_cnt = pwm_cnt;
    next_loop_cnt = loop_cnt + 16'h0001;
    next_loop_duty = loop_duty;
    if (tick_cnt == 16'(FCC_PWM_TICK_CYC - 1)) begin
      next_tick_cnt = 16'h0000;
      next_pwm_cnt = pwm_cnt + 8'h01;
    end
    if (loop_cnt == 16'(FCC_LOOP_CYC - 1)) begin
      next_loop_cnt = 16'h0000;
      // a larger speed_pulse_input count means a slower fan
      if (cfg_a[FCC_A_START] && mode == FCC_MODE_SPEED) begin // RULE7
        if (speed_pulse_input > target_speed && loop_duty != 8'hff) begin
          next_loop_duty = loop_duty + 8'h01;
        end else if (speed_pulse_input < target_speed &&
                     loop_duty != 8'h00) begin
          next_loop_duty = loop_duty - 8'h01;
        end
      end
    end
    if (soft_reset) begin
      next_loop_duty = 8'h00;
    end
    // inverted mode relies on an external pull-up for the on level
    next_pwm_out = cfg_a[FCC_A_POL] ? 1'b0 : ~pulse_on; // RULE9
    next_pwm_oe_n = cfg_a[FCC_A_POL] ? pulse_on : 1'b0; // RULE9
    next_overtemp_output_pin_n = ~ovt_any; // RULE2
    next_fault_oe_n = ~(cfg_a[FCC_A_FAULT_EN] & spd_any); // RULE8
    next_speed_range_irq = cfg_a[FCC_A_SPD_IE] & spd_any; // RULE10
    next_smb_alert_oe_n = ~(cfg_a[FCC_A_GLB_IE] & irq_any); // RULE12 RULE16
  end

  assign pulse_on = (duty_now == 8'hff) || (pwm_cnt < duty_now);
  assign ovt_any = local_overtemp_flag | remote_overtemp_flag;
  assign spd_any = fan_stall_flag | speed_limit_flag;
  assign irq_any = (cfg_a[FCC_A_OVT_IE] & ovt_any) | // RULE1 RULE2
    (cfg_a[FCC_A_SPD_IE] & spd_any); // RULE10 RULE11

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 16'h0000;
      pwm_cnt <= 8'h00;
      loop_cnt <= 16'h0000;
      loop_duty <= 8'h00;
      pwm_out <= 1'b1;
      pwm_oe_n <= 1'b0;
      overtemp_output_pin_n <= 1'b1;
      fault_oe_n <= 1'b1;
      speed_range_irq <= 1'b0;
      smb_alert_oe_n <= 1'b1;
    end else begin
      tick_cnt <= next_tick_cnt;
      pwm_cnt <= next_pwm_cnt;
      loop_cnt <= next_loop_cnt;
      loop_duty <= next_loop_duty;
      pwm_out <= next_pwm_out;
      pwm_oe_n <= next_pwm_oe_n;
      overtemp_output_pin_n <= next_overtemp_output_pin_n;
      fault_oe_n <= next_fault_oe_n;
      speed_range_irq <= next_speed_range_irq;
      smb_alert_oe_n <= next_smb_alert_oe_n;
    end
  end

  // ==========================================================
  // checks
  sequence s_srst_bit;
    st == FCC_ST_WDATA && scl_rise && bitcnt == 4'h7 &&
      ptr == FCC_CFG_B_OFS && shreg[6] && !bus_stop && !bus_start;
  endsequence
  sequence s_srst_done;
    soft_reset ##1 (cfg_a == FCC_CFG_A_RST && !cfg_b[FCC_B_SRST]);
  endsequence

  property p_ovt_irq;
    @(posedge clk) disable iff (!rst_n)
    (cfg_a[FCC_A_OVT_IE] && cfg_a[FCC_A_GLB_IE] && ovt_any)
      |=> !smb_alert_oe_n;
  endproperty
  a_ovt_irq: assert property (p_ovt_irq) // RULE1
    else $error("overtemp did not raise alert");
  property p_ovt_masked;
    @(posedge clk) disable iff (!rst_n)
    (!cfg_a[FCC_A_OVT_IE] && !(cfg_a[FCC_A_SPD_IE] && spd_any) && ovt_any)
      |=> (smb_alert_oe_n && !overtemp_output_pin_n);
  endproperty
  a_ovt_masked: assert property (p_ovt_masked) // RULE2
    else $error("masked overtemp misbehaved");
  property p_max_mode;
    @(posedge clk) disable iff (!rst_n)
    (mode == FCC_MODE_MAX && cfg_a[FCC_A_START])
      |-> (duty_now >= rem_duty && duty_now >= loc_duty);
  endproperty
  a_max_mode: assert property (p_max_mode) // RULE4
    else $error("max mode duty too small");
  property p_sw_duty;
    @(posedge clk) disable iff (!rst_n)
    mode == FCC_MODE_DUTY |-> duty_now == duty_setting_reg;
  endproperty
  a_sw_duty: assert property (p_sw_duty) // RULE6
    else $error("software duty not passed through");
  property p_fault_off;
    @(posedge clk) disable iff (!rst_n)
    !cfg_a[FCC_A_FAULT_EN] |=> fault_oe_n;
  endproperty
  a_fault_off: assert property (p_fault_off) // RULE8
    else $error("fault pin driven while disabled");
  property p_full_duty;
    @(posedge clk) disable iff (!rst_n)
    (duty_now == 8'hff) |=> ($past(cfg_a[FCC_A_POL]) ? pwm_oe_n :
      (!pwm_oe_n && !pwm_out));
  endproperty
  a_full_duty: assert property (p_full_duty) // RULE9
    else $error("wrong pwm level at full duty");
  property p_spd_masked;
    @(posedge clk) disable iff (!rst_n)
    !cfg_a[FCC_A_SPD_IE] |=> !speed_range_irq;
  endproperty
  a_spd_masked: assert property (p_spd_masked) // RULE11
    else $error("fan interrupt while disabled");
  property p_glb_gate;
    @(posedge clk) disable iff (!rst_n)
    !cfg_a[FCC_A_GLB_IE] |=> smb_alert_oe_n;
  endproperty
  a_glb_gate: assert property (p_glb_gate) // RULE12
    else $error("alert while globally disabled");
  property p_idle_stop;
    @(posedge clk) disable iff (!rst_n)
    (!cfg_a[FCC_A_START] && mode != FCC_MODE_DUTY) |-> duty_now == 8'h00;
  endproperty
  a_idle_stop: assert property (p_idle_stop) // RULE13
    else $error("automatic duty while not started");
  property p_srst;
    @(posedge clk) disable iff (!rst_n)
    s_srst_bit |=> s_srst_done;
  endproperty
  a_srst: assert property (p_srst) // RULE14
    else $error("soft reset did not restore registers");
  property p_srst_nack;
    @(posedge clk) disable iff (!rst_n)
    s_srst_bit |=> (smb_sda_oe_n && st == FCC_ST_IDLE) [*2];
  endproperty
  a_srst_nack: assert property (p_srst_nack) // RULE15
    else $error("soft reset write was acknowledged");
endmodule
`default_nettype wire

/* dv/fcc_smb_host.sv */
`timescale 1ns/1ns
`default_nettype none
module fcc_smb_host #(
  parameter logic [6:0] ADDR = 7'h18
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // ==========================================================
  // bit level; every scl phase spans at least 3 clk
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start_c();
    tick(2);
    sda_pull <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask
  task automatic stop_c();
    tick(2);
    sda_pull <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b0;
    tick(4);
  endtask
  // sample on the falling clk edge, away from the device's flop updates
  task automatic bit_c(input logic b, output logic r);
    tick(2);
    sda_pull <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    @(negedge clk);
    r = sda_line;
    @(posedge clk);
    scl <= 1'b0;
  endtask
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], r);
    end
    bit_c(1'b1, r);
    ack = ~r;
  endtask
  task automatic byte_r(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, d[i]);
    end
    // nack ends the read
    bit_c(1'b1, r);
  endtask
  // ==========================================================
  // byte transactions addressed by register offset
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d,
                    output logic ack);
    logic a;
    start_c();
    byte_w({ADDR, 1'b0}, a);
    byte_w(ofs, a);
    byte_w(d, ack);
    stop_c();
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    logic a;
    start_c();
    byte_w({ADDR, 1'b0}, a);
    byte_w(ofs, a);
    start_c();
    byte_w({ADDR, 1'b1}, a);
    byte_r(d);
    stop_c();
  endtask
endmodule
`default_nettype wire

/* dv/fcc_fan_ctrl_config_regs_test.sv */
`timescale 1ns/1ns
`default_nettype none
module fcc_fan_ctrl_config_regs_test import fcc_pkg::*;;
  // ==========================================================
  // signals and tables
  typedef struct packed {
    logic [7:0] cfg;
    logic [3:0] flg;
    logic [3:0] exp;
  } fcc_irq_row_t;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] duty;
    logic [7:0] rt;
    logic [7:0] lt;
    logic [15:0] lo;
  } fcc_pwm_row_t;
  // flg: local, remote, stall, limit; exp: alert_n, ovt_n, fault_n, irq
  localparam fcc_irq_row_t IRQ_ROWS [8] = '{
    '{8'h82, 4'h8, 4'h2}, '{8'h82, 4'h4, 4'h2}, '{8'h02, 4'h8, 4'ha},
    '{8'h16, 4'h2, 4'h5}, '{8'h16, 4'h1, 4'h5}, '{8'h02, 4'h3, 4'he},
    '{8'h94, 4'hf, 4'h9}, '{8'h86, 4'h0, 4'he}};
  // lo: cycles with the pwm line low over one full period
  localparam fcc_pwm_row_t PWM_ROWS [12] = '{
    '{8'h00, 8'hff, 8'h00, 8'h00, 16'h0a00},
    '{8'h00, 8'h00, 8'h00, 8'h00, 16'h0000},
    '{8'h00, 8'h80, 8'h00, 8'h00, 16'h0500},
    '{8'h08, 8'hff, 8'h00, 8'h00, 16'h0000},
    '{8'h08, 8'h00, 8'h00, 8'h00, 16'h0a00},
    '{8'h41, 8'h00, 8'h50, 8'h00, 16'h0a00},
    '{8'h41, 8'hff, 8'h28, 8'h50, 16'h0000},
    '{8'h40, 8'hff, 8'h50, 8'h00, 16'h0000},
    '{8'h61, 8'h00, 8'h00, 8'h50, 16'h0a00},
    '{8'h61, 8'h00, 8'h30, 8'h2c, 16'h0140},
    '{8'h60, 8'hff, 8'h50, 8'h50, 16'h0000},
    '{8'h01, 8'h40, 8'h50, 8'h50, 16'h0280}};
  logic clk, rst_n, scl, sda_pull, lflag, rflag, stall, limit;
  logic [7:0] ltemp, rtemp, duty;
  logic [15:0] target, meas;
  wire logic sda_line, sda_out, sda_oe_n, alert_oe_n, ovt_n, fault_oe_n;
  wire logic spd_irq, pwm_out, pwm_oe_n, srst, pwm_line;
  int n_mismatch, n_tests, n_srst;
  // both lines carry pull-ups; the device drives its data value when enabled
  assign sda_line = ~sda_pull & (sda_oe_n | sda_out);
  assign pwm_line = pwm_oe_n ? 1'b1 : pwm_out;
  fcc_fan_ctrl_config_regs uut (
    .clk(clk), .rst_n(rst_n), .smb_scl(scl), .smb_sda_in(sda_line),
    .smb_sda_out(sda_out), .smb_sda_oe_n(sda_oe_n),
    .smb_alert_oe_n(alert_oe_n), .local_overtemp_flag(lflag),
    .remote_overtemp_flag(rflag), .fan_stall_flag(stall),
    .speed_limit_flag(limit), .local_temp(ltemp), .remote_temp(rtemp),
    .duty_setting_reg(duty), .target_speed(target),
    .speed_pulse_input(meas), .overtemp_output_pin_n(ovt_n),
    .fault_oe_n(fault_oe_n), .speed_range_irq(spd_irq),
    .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .soft_reset(srst));
  fcc_smb_host host (
    .clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));
  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wcfg(input logic [7:0] v);
    logic a;
    logic [7:0] d;
    host.wr(FCC_CFG_A_OFS, v, a);
    chk(16'(a), 16'h0001);
    host.rd(FCC_CFG_A_OFS, d);
    chk(16'(d), 16'(v));
  endtask
  task automatic low_cnt(output logic [15:0] c);
    c = 16'h0000;
    repeat (256 * FCC_PWM_TICK_CYC) begin
      @(negedge clk);
      if (pwm_line === 1'b0) c = c + 16'h0001;
    end
  endtask
  // ==========================================================
  // stimulus
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (srst === 1'b1) n_srst++;
  end
  initial begin
    fcc_irq_row_t ir;
    fcc_pwm_row_t pr;
    logic [7:0] d;
    logic [15:0] c;
    logic a;
    logic [3:0] g;
    n_mismatch = 0;
    n_tests = 0;
    n_srst = 0;
    rst_n = 1'b0;
    {lflag, rflag, stall, limit} = 4'h8;
    ltemp = 8'h00;
    rtemp = 8'h00;
    duty = 8'h00;
    target = 16'h0100;
    meas = 16'h0100;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(16'({alert_oe_n, ovt_n}), 16'h0002);
    host.rd(FCC_CFG_A_OFS, d);
    chk(16'(d), 16'(FCC_CFG_A_RST));
    host.rd(FCC_CFG_B_OFS, d);
    chk(16'(d), 16'(FCC_CFG_B_RST));
    host.wr(8'h05, 8'h5a, a);
    host.rd(8'h05, d);
    chk(16'(d), 16'h0000);
    foreach (IRQ_ROWS[i]) begin
      ir = IRQ_ROWS[i];
      wcfg(ir.cfg);
      {lflag, rflag, stall, limit} <= ir.flg;
      repeat (3) @(posedge clk);
      @(negedge clk);
      g = {alert_oe_n, ovt_n, fault_oe_n, spd_irq};
      chk(16'(g[3]), 16'(ir.exp[3]));
      chk(16'(g[2:1]), 16'(ir.exp[2:1]));
      chk(16'(g[0]), 16'(ir.exp[0]));
    end
    @(posedge clk);
    {lflag, rflag, stall, limit} <= 4'h0;
    foreach (PWM_ROWS[i]) begin
      pr = PWM_ROWS[i];
      wcfg(pr.cfg);
      duty <= pr.duty;
      rtemp <= pr.rt;
      ltemp <= pr.lt;
      // a full period first, in case duty is taken at period start
      repeat (256 * FCC_PWM_TICK_CYC + 8) @(posedge clk);
      low_cnt(c);
      chk(c, pr.lo);
    end
    wcfg(8'h21);
    meas <= 16'h0200;
    repeat (6000) @(posedge clk);
    low_cnt(c);
    chk(16'(c != 16'h0000), 16'h0001);
    @(posedge clk);
    meas <= 16'h0080;
    repeat (12000) @(posedge clk);
    low_cnt(c);
    chk(c, 16'h0000);
    host.wr(FCC_CFG_B_OFS, 8'h05, a);
    host.rd(FCC_CFG_B_OFS, d);
    chk(16'(d), 16'h0005);
    host.wr(FCC_CFG_B_OFS, 8'h80, a);
    chk(16'(a), 16'h0000);
    chk(16'(n_srst), 16'h0001);
    host.rd(FCC_CFG_A_OFS, d);
    chk(16'(d), 16'(FCC_CFG_A_RST));
    host.rd(FCC_CFG_B_OFS, d);
    chk(16'(d), 16'(FCC_CFG_B_RST));
    close_out();
  end
endmodule
`default_nettype wire
